// >>> verilog/drive_rail_fault_response.sv
// Function
// - Keep own overvoltage response configuration byte.
// - Keep undervoltage response byte, same layout.
// - Mode 00 ignores; 01 delays, disables, retries.
// - Mode 10 disables at once, then retries.
// - Mode 11 disables while fault persists only.
// - Fault sets sticky status; only clear-faults or reset clears.
// - Retry 000 means stay disabled, no restart.
// - Retry 001-110 gives that many spaced restarts.
// - Retry 111 restarts endlessly until output disabled.
// - Time count sets delay and restart spacing.
// - Both response bytes reset to 80h.
// - Overvoltage when rail exceeds overvoltage threshold.
// - Undervoltage when rail below undervoltage threshold.
`timescale 1ns/1ps
module drive_rail_fault_response #(
    parameter int unsigned UNIT_CYCLES = drive_rail_pkg::TIME_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Configuration command port
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  cmd_data,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_error,
    // Driver supply monitor
    input  wire logic [15:0] driver_supply_monitor,
    input  wire logic [15:0] drive_rail_overvoltage_threshold,
    input  wire logic [15:0] drive_rail_undervoltage_threshold,
    // Output control
    input  wire logic        enable_request,
    output logic             output_enable,
    output logic [1:0]       fault_status
);
    import drive_rail_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    // Per-channel arrays are indexed by CH_OV and CH_UV throughout.
    logic [7:0]  resp_cfg   [NUM_CH]; // Response bytes, overvoltage first.
    resp_state_e state      [NUM_CH]; // Sequencer state per channel.
    logic [15:0] cnt        [NUM_CH]; // Delay and spacing down-counter.
    logic [2:0]  tries      [NUM_CH]; // Restart attempts used so far.
    logic [1:0]  fault_now;           // Live comparator result per channel.
    logic [1:0]  allow;               // Channel lets the output run.
    logic        wr_cmd;              // A write command this cycle.
    logic        clear_cmd;           // Clear-faults command this cycle.

    // Command decode; a clear is a write of the clear-faults code, its data unused.
    assign wr_cmd    = cmd_valid && cmd_write;
    assign clear_cmd = wr_cmd && (cmd_code == CLEAR_FAULTS_CODE);

    // Comparators; equality with a threshold is not a fault.
    assign fault_now[CH_OV] = driver_supply_monitor > drive_rail_overvoltage_threshold;
    assign fault_now[CH_UV] = driver_supply_monitor < drive_rail_undervoltage_threshold;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Writes land one cycle after the command; no write protection here.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_cfg[CH_OV] <= RESP_RESET;
            resp_cfg[CH_UV] <= RESP_RESET;
        end else if (wr_cmd && (cmd_code == OV_RESP_CODE)) begin
            resp_cfg[CH_OV] <= cmd_data;
        end else if (wr_cmd && (cmd_code == UV_RESP_CODE)) begin
            resp_cfg[CH_UV] <= cmd_data;
        end
    end

    // Read answers come one cycle later; unknown codes read zero and flag.
    // The data byte holds between reads so a slow host can still pick it up.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            rsp_error <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid && !cmd_write;
            if (cmd_valid && !cmd_write && (cmd_code == OV_RESP_CODE)) begin
                rsp_data  <= resp_cfg[CH_OV];
                rsp_error <= 1'b0;
            end else if (cmd_valid && !cmd_write && (cmd_code == UV_RESP_CODE)) begin
                rsp_data  <= resp_cfg[CH_UV];
                rsp_error <= 1'b0;
            end else if (cmd_valid && !cmd_write) begin
                rsp_data  <= 8'h00;
                rsp_error <= 1'b1;
            end else begin
                rsp_data  <= rsp_data;
                rsp_error <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Fault response sequencers
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            logic [1:0]  mode;  // Response behaviour field.
            logic [2:0]  retry; // Retry setting field.
            logic [15:0] load;  // Delay or spacing length in cycles.
            logic        retry_left; // Another restart is permitted.

            // Field slices of this channel's response byte.
            assign mode  = resp_cfg[i][MODE_HI:MODE_LO];
            assign retry = resp_cfg[i][RETRY_HI:RETRY_LO];
            // Zero time count still costs one cycle of the counter.
            assign load  = 16'(32'(resp_cfg[i][TIME_HI:TIME_LO]) * UNIT_CYCLES);
            assign retry_left = (retry == RETRY_ENDLESS) || (tries[i] < retry);

            // RUN: output allowed, fault watched. DELAY: output still allowed
            // while the reaction time runs. SPACING: output off until the
            // next restart. HOLD: output off while the fault lasts. LATCHED:
            // output off until the enable request drops.
            // Configuration is read live rather than captured at the fault,
            // so a host rewrite takes effect at the next decision; that keeps
            // the logic small, but a rewrite mid-sequence changes its course.
            // Dropping the enable request is the restart by other means; it
            // also ends an endless retry loop.
            always_ff @(posedge clk) begin
                if (sys_rst || !enable_request) begin
                    state[i] <= ST_RUN;
                    cnt[i]   <= 16'h0000;
                    tries[i] <= 3'h0;
                end else begin
                    case (state[i])
                        ST_RUN: begin
                            if (fault_now[i] && (mode == MODE_DELAY)) begin
                                state[i] <= ST_DELAY;
                                cnt[i]   <= load;
                            end else if (fault_now[i] && (mode == MODE_HOLD)) begin
                                state[i] <= ST_HOLD;
                            end else if (fault_now[i] && (mode == MODE_DISABLE)) begin
                                // Shut off at once, then decide on a restart.
                                if ((retry != RETRY_NONE) && retry_left) begin
                                    state[i] <= ST_SPACING;
                                    cnt[i]   <= load;
                                    if (retry != RETRY_ENDLESS) begin
                                        tries[i] <= tries[i] + 3'h1;
                                    end
                                end else begin
                                    state[i] <= ST_LATCHED;
                                end
                            end
                        end
                        ST_DELAY: begin
                            // Output still runs while the reaction is delayed.
                            if (cnt[i] > 16'h0001) begin
                                cnt[i] <= cnt[i] - 16'h0001;
                            end else if ((retry != RETRY_NONE) && retry_left) begin
                                state[i] <= ST_SPACING;
                                cnt[i]   <= load;
                                if (retry != RETRY_ENDLESS) begin
                                    tries[i] <= tries[i] + 3'h1;
                                end
                            end else begin
                                state[i] <= ST_LATCHED;
                            end
                        end
                        ST_HOLD: begin
                            if (!fault_now[i]) begin
                                state[i] <= ST_RUN;
                            end
                        end
                        ST_SPACING: begin
                            // The restart does not look at the fault; a fault
                            // still present is simply caught again in RUN.
                            if (cnt[i] > 16'h0001) begin
                                cnt[i] <= cnt[i] - 16'h0001;
                            end else begin
                                state[i] <= ST_RUN;
                            end
                        end
                        default: begin
                            state[i] <= ST_LATCHED;
                        end
                    endcase
                end
            end

            assign allow[i] = (state[i] == ST_RUN) || (state[i] == ST_DELAY);

            // Sticky status: a fault in the clearing cycle keeps the bit set.
            // Status is set whatever the response mode, ignore included.
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    fault_status[i] <= 1'b0;
                end else if (fault_now[i]) begin
                    fault_status[i] <= 1'b1;
                end else if (clear_cmd) begin
                    fault_status[i] <= 1'b0;
                end
            end

            // ********************************************************
            // Checks per channel
            // ********************************************************
            ignore_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_RUN) && (mode == MODE_IGNORE) && enable_request
                |=> (state[i] == ST_RUN))
                else $error("ignore mode left the run state");
            disable_now_a: assert property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_RUN) && fault_now[i] && (mode == MODE_DISABLE) && enable_request
                |=> !allow[i] ##1 !output_enable)
                else $error("disable mode did not shut the output");
            hold_release_a: assert property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_HOLD) && !fault_now[i] && enable_request
                |=> (state[i] == ST_RUN))
                else $error("hold mode did not release");
            status_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
                fault_status[i] && !clear_cmd |=> fault_status[i])
                else $error("fault status dropped without clear");
            fault_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
                fault_now[i] |=> fault_status[i])
                else $error("detected fault did not set status");
            latched_stays_a: assert property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_LATCHED) && enable_request |=> (state[i] == ST_LATCHED))
                else $error("latched channel restarted by itself");
            tries_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
                (retry != RETRY_ENDLESS) && $changed(tries[i]) && (tries[i] != 3'h0)
                |-> (tries[i] <= retry))
                else $error("more restarts than the retry setting");
            spacing_len_a: assert property (@(posedge clk) disable iff (sys_rst)
                $rose(state[i] == ST_SPACING) && enable_request |-> (cnt[i] == load))
                else $error("spacing count not loaded from time field");
            // A finished spacing always hands the channel back to RUN.
            spacing_end_a: assert property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_SPACING) && (cnt[i] <= 16'h0001) && enable_request
                |=> (state[i] == ST_RUN))
                else $error("spacing did not end in a restart");
            // A delayed reaction keeps counting before it acts.
            delay_runs_a: assert property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_DELAY) && (cnt[i] > 16'h0001) && enable_request
                |=> (state[i] == ST_DELAY))
                else $error("delayed reaction cut short");

            // Scenarios worth seeing: a restart, a hold release and a delayed latch.
            retry_seen_c: cover property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_SPACING) ##1 (state[i] == ST_RUN));
            hold_seen_c: cover property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_HOLD) ##1 (state[i] == ST_RUN));
            latch_seen_c: cover property (@(posedge clk) disable iff (sys_rst)
                (state[i] == ST_DELAY) ##1 (state[i] == ST_LATCHED));
        end
    endgenerate

    // ************************************************************
    // Output enable
    // ************************************************************
    // Registered so the pin never glitches; costs one cycle of reaction.
    // Either channel withdrawing its allow turns the output off; the two
    // channels never wait for each other.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            output_enable <= 1'b0;
        end else begin
            output_enable <= enable_request && (&allow);
        end
    end

    ov_cfg_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_cmd && (cmd_code == OV_RESP_CODE) |=> (resp_cfg[CH_OV] == $past(cmd_data)))
        else $error("overvoltage response byte not written");
    uv_cfg_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_cmd && (cmd_code == UV_RESP_CODE) |=> (resp_cfg[CH_UV] == $past(cmd_data)))
        else $error("undervoltage response byte not written");
    // Judged one edge after reset is seen, so the first edge of the run,
    // before reset has taken effect, is not judged.
    reset_value_a: assert property (@(posedge clk)
        sys_rst |=> (resp_cfg[CH_OV] == RESP_RESET) && (resp_cfg[CH_UV] == RESP_RESET))
        else $error("response byte reset value wrong");

    // ************************************************************
    // Command port and output checks
    // ************************************************************
    // A read is always answered on the next edge, mapped or not.
    read_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid && !cmd_write |=> rsp_valid)
        else $error("read command got no answer");
    read_ov_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid && !cmd_write && (cmd_code == OV_RESP_CODE)
        |=> (rsp_data == $past(resp_cfg[CH_OV])) && !rsp_error)
        else $error("overvoltage response byte read back wrong");
    read_uv_a: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid && !cmd_write && (cmd_code == UV_RESP_CODE)
        |=> (rsp_data == $past(resp_cfg[CH_UV])) && !rsp_error)
        else $error("undervoltage response byte read back wrong");
    // A clear with no live fault must leave both status bits low.
    clear_status_a: assert property (@(posedge clk) disable iff (sys_rst)
        clear_cmd && (fault_now == 2'h0) |=> (fault_status == 2'h0))
        else $error("clear-faults left a status bit set");
    // Dropping the enable request turns the output off on the next edge.
    enable_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !enable_request |=> !output_enable)
        else $error("output stayed on without an enable request");

endmodule : drive_rail_fault_response

// >>> verilog/drive_rail_pkg.sv
package drive_rail_pkg;

    // ************************************************************
    // Command codes of the configuration port
    // ************************************************************
    localparam logic [7:0] OV_RESP_CODE      = 8'hF8; // Overvoltage response byte.
    localparam logic [7:0] UV_RESP_CODE      = 8'hF9; // Undervoltage response byte.
    localparam logic [7:0] CLEAR_FAULTS_CODE = 8'h03; // Send-byte that clears status.

    // ************************************************************
    // Field layout and reset value of a response byte
    // ************************************************************
    localparam logic [7:0] RESP_RESET = 8'h80; // Disable and no retry.
    localparam int         MODE_HI    = 7;     // Response behaviour, upper bit.
    localparam int         MODE_LO    = 6;     // Response behaviour, lower bit.
    localparam int         RETRY_HI   = 5;     // Retry setting, upper bit.
    localparam int         RETRY_LO   = 3;     // Retry setting, lower bit.
    localparam int         TIME_HI    = 2;     // Retry and delay time, upper bit.
    localparam int         TIME_LO    = 0;     // Retry and delay time, lower bit.

    localparam logic [1:0] MODE_IGNORE  = 2'h0; // Keep running.
    localparam logic [1:0] MODE_DELAY   = 2'h1; // Delay, disable, retry.
    localparam logic [1:0] MODE_DISABLE = 2'h2; // Disable at once, retry.
    localparam logic [1:0] MODE_HOLD    = 2'h3; // Disabled while fault lasts.

    localparam logic [2:0] RETRY_NONE    = 3'h0; // No restart attempt.
    localparam logic [2:0] RETRY_ENDLESS = 3'h7; // Restart without end.

    // ************************************************************
    // Channels and timing
    // ************************************************************
    localparam int CH_OV  = 0; // Overvoltage channel index.
    localparam int CH_UV  = 1; // Undervoltage channel index.
    localparam int NUM_CH = 2; // Number of fault channels.

    localparam int CLK_PERIOD_NS    = 100;   // 10 MHz system clock.
    localparam int TIME_UNIT_NS     = 10000; // One step of the three-bit time count.
    localparam int TIME_UNIT_CYCLES = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Per-channel response sequencer states.
    typedef enum logic [2:0] {
        ST_RUN,
        ST_DELAY,
        ST_HOLD,
        ST_SPACING,
        ST_LATCHED
    } resp_state_e;

endpackage : drive_rail_pkg

// >>> dv/host_model.sv
`timescale 1ns/1ps
// ************************************************************
// Host that issues configuration commands
// ************************************************************
module host_model (
    // Clock
    input  wire logic       clk,
    // Command port
    output logic            cmd_valid,
    output logic            cmd_write,
    output logic [7:0]      cmd_code,
    output logic [7:0]      cmd_data,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data,
    input  wire logic       rsp_error
);
    // Idle values at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_data  = 8'h00;
    end
    // One command, held over one edge; code and data are inverted afterwards
    // so that a design which samples outside the strobe sees garbage.
    task automatic issue(input logic wr, input logic [7:0] code, input logic [7:0] data);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code  <= code;
        cmd_data  <= data;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code  <= ~code;
        cmd_data  <= ~data;
    endtask : issue
    // Read: the answer stands for one cycle right after the taking edge.
    task automatic read_byte(input logic [7:0] code, output logic [7:0] data,
                             output logic err, output logic ok);
        issue(1'b0, code, 8'h00);
        #1;
        ok   = rsp_valid;
        data = rsp_data;
        err  = rsp_error;
    endtask : read_byte
endmodule : host_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
// ************************************************************
// Self-checking bench for the fault response block
// ************************************************************
module testbench;
    import drive_rail_pkg::*;
    localparam int UNIT = 2;          // Short time step keeps delays visible but fast.
    logic        clk = 1'b0;          // System clock.
    logic        sys_rst = 1'b1;      // Synchronous reset.
    logic        cmd_valid, cmd_write, rsp_valid, rsp_error, output_enable;
    logic [7:0]  cmd_code, cmd_data, rsp_data;
    logic [15:0] mon = 16'h02BC;      // Rail reading, healthy between thresholds.
    logic [15:0] ov_lim = 16'h03E8;   // Overvoltage threshold, programmable.
    logic [15:0] uv_lim = 16'h01F4;   // Undervoltage threshold, programmable.
    logic        enable_request = 1'b0;
    logic [1:0]  fault_status;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 19432;
    logic [7:0]  reg_m [2];           // Model of both response bytes.
    logic [1:0]  stat_m;              // Model of the sticky status.
    logic [7:0]  rd;
    logic        er, ok;
    int          r;
    always #50 clk = ~clk;
    host_model HOST (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_error(rsp_error));
    drive_rail_fault_response #(.UNIT_CYCLES(UNIT)) DUT (.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_error(rsp_error), .driver_supply_monitor(mon),
        .drive_rail_overvoltage_threshold(ov_lim),
        .drive_rail_undervoltage_threshold(uv_lim), .enable_request(enable_request),
        .output_enable(output_enable), .fault_status(fault_status));
    // Verdict, reached from the main sequence or from an exhausted wait.
    task automatic tally_and_finish();
        $display("Counts: %0d compared, %0d mismatched", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Writes update the model; unmapped codes leave it alone.
    task automatic wr(input logic [7:0] code, input logic [7:0] d);
        HOST.issue(1'b1, code, d);
        if (code == OV_RESP_CODE) reg_m[0] = d;
        if (code == UV_RESP_CODE) reg_m[1] = d;
        if (code == CLEAR_FAULTS_CODE) stat_m = 2'h0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] code);
        HOST.read_byte(code, rd, er, ok);
        `CHK(ok, 1'b1)
        `CHK(er, !(code == OV_RESP_CODE || code == UV_RESP_CODE))
        `CHK(rd, code == OV_RESP_CODE ? reg_m[0] : code == UV_RESP_CODE ? reg_m[1] : 8'h00)
    endtask : rd_chk
    // Bounded wait for the output to reach a level.
    task automatic wait_oe(input logic v, input int bound);
        int i;
        for (i = 0; i < bound && output_enable !== v; i++) cyc(1);
        if (output_enable !== v) begin
            n_fail++;
            $display("ERROR t=%0t output wait ran out, got %h exp %h", $time, output_enable, v);
            tally_and_finish();
        end
    endtask : wait_oe
    task automatic rises(input int n, output int cnt);
        logic last;
        last = output_enable;
        cnt  = 0;
        repeat (n) begin
            cyc(1);
            if (output_enable === 1'b1 && last !== 1'b1) cnt++;
            last = output_enable;
        end
    endtask : rises
    task automatic restart();
        enable_request <= 1'b0;
        cyc(2);
        `CHK(output_enable, 1'b0)
        enable_request <= 1'b1;
        wait_oe(1'b1, 5);
    endtask : restart
    task automatic stat_chk();
        cyc(2);
        `CHK(fault_status, stat_m)
    endtask : stat_chk
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        reg_m[0] = RESP_RESET;
        reg_m[1] = RESP_RESET;
        stat_m   = 2'h0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        `CHK(output_enable, 1'b0)
        rd_chk(OV_RESP_CODE);
        rd_chk(UV_RESP_CODE);
        rd_chk(8'hF7);
        stat_chk();
        $display("Test reset values done");
        repeat (4) begin
            wr(OV_RESP_CODE, 8'($random(seed)));
            wr(UV_RESP_CODE, 8'($random(seed)));
            wr(8'hFA, 8'($random(seed)));
            rd_chk(OV_RESP_CODE);
            rd_chk(UV_RESP_CODE);
        end
        $display("Test register access done");
        // A reset in mid-run brings both bytes back to their reset value.
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        reg_m[0] = RESP_RESET;
        reg_m[1] = RESP_RESET;
        `CHK(output_enable, 1'b0)
        rd_chk(OV_RESP_CODE);
        rd_chk(UV_RESP_CODE);
        stat_chk();
        $display("Test mid-run reset done");
        wr(OV_RESP_CODE, RESP_RESET);
        wr(UV_RESP_CODE, 8'h00);
        restart();
        mon <= 16'h03E9;
        cyc(1);
        mon <= 16'h02BC;
        stat_m[CH_OV] = 1'b1;
        wait_oe(1'b0, 4);
        cyc(10);
        `CHK(output_enable, 1'b0)
        stat_chk();
        restart();
        stat_chk();
        $display("Test disable without retry done");
        wr(OV_RESP_CODE, 8'h00);
        wr(CLEAR_FAULTS_CODE, 8'h00);
        stat_chk();
        mon <= 16'h03E9;
        ov_lim <= 16'h03E9;
        stat_chk();
        ov_lim <= 16'h03E8;
        stat_m[CH_OV] = 1'b1;
        rises(10, r);
        `CHK(r, 0)
        `CHK(output_enable, 1'b1)
        stat_chk();
        // A clear that meets a live fault leaves the bit set.
        wr(CLEAR_FAULTS_CODE, 8'h00);
        stat_m[CH_OV] = 1'b1;
        stat_chk();
        mon <= 16'h02BC;
        $display("Test ignore mode done");
        wr(OV_RESP_CODE, 8'h91);
        restart();
        mon <= 16'h03E9;
        rises(60, r);
        `CHK(r, 2)
        `CHK(output_enable, 1'b0)
        wr(OV_RESP_CODE, 8'hB9);
        restart();
        rises(60, r);
        `CHK(r > 7, 1'b1)
        mon <= 16'h02BC;
        $display("Test retry counts done");
        wr(UV_RESP_CODE, 8'h43);
        restart();
        mon <= 16'h01F3;
        stat_m[CH_UV] = 1'b1;
        repeat (7) begin
            cyc(1);
            `CHK(output_enable, 1'b1)
        end
        wait_oe(1'b0, 2);
        mon <= 16'h02BC;
        cyc(10);
        `CHK(output_enable, 1'b0)
        stat_chk();
        // Delay, one restart, delay again, then latched.
        wr(UV_RESP_CODE, 8'h4A);
        restart();
        mon <= 16'h01F3;
        rises(20, r);
        `CHK(r, 1)
        `CHK(output_enable, 1'b0)
        mon <= 16'h02BC;
        $display("Test delayed disable done");
        wr(UV_RESP_CODE, 8'hC0);
        restart();
        uv_lim <= 16'h02BD;
        wait_oe(1'b0, 4);
        cyc(10);
        `CHK(output_enable, 1'b0)
        uv_lim <= 16'h01F4;
        wait_oe(1'b1, 4);
        stat_chk();
        wr(CLEAR_FAULTS_CODE, 8'h00);
        stat_chk();
        $display("Test hold mode and clear done");
        tally_and_finish();
    end
endmodule : testbench
